// >>> src/exec_pkg.sv
// Purpose: Shared constants and types for the logic/bit-op executor.
// Assumes: 8-bit data path, 16-bit instruction words.
// Notes:   Offsets are word indices on the plain register port.
package exec_pkg;
    // Register port offsets
    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_WORK   = 4'h1;
    localparam logic [3:0] OFS_STATUS = 4'h2;
    localparam logic [3:0] OFS_STATE  = 4'h3;
    // Field positions
    localparam int CTRL_RUN_BIT = 0;
    localparam int ST_C_BIT     = 0;
    localparam int ST_DC_BIT    = 1;
    localparam int ST_Z_BIT     = 2;
    localparam int ST_OV_BIT    = 3;
    localparam int STATE_SKIP   = 2;
    // Reset values
    localparam logic       CTRL_RST   = 1'b0;
    localparam logic [7:0] WORK_RST   = 8'h00;
    localparam logic [3:0] STATUS_RST = 4'h0;
    // Opcode patterns
    localparam logic [7:0] OPC_AND_LIT  = 8'hB5;
    localparam logic [6:0] OPC_AND_FILE = 7'h05;
    localparam logic [6:0] OPC_ADD_C    = 7'h08;
    localparam logic [4:0] OPC_BIT_CLR  = 5'h11;
    localparam logic [4:0] OPC_BIT_SET  = 5'h10;
    localparam logic [4:0] OPC_SKIP_CLR = 5'h13;
    localparam logic [4:0] OPC_SKIP_SET = 5'h12;
    // Quarter cycles per instruction cycle
    localparam int PHASES = 4;

    typedef enum logic [1:0] {
        ph_decode  = 2'b00,
        ph_read    = 2'b01,
        ph_process = 2'b10,
        ph_write   = 2'b11
    } phase_type;

    typedef enum logic [2:0] {
        op_nop      = 3'b000,
        op_and_lit  = 3'b001,
        op_and_file = 3'b010,
        op_bit_clr  = 3'b011,
        op_bit_set  = 3'b100,
        op_skip_clr = 3'b101,
        op_skip_set = 3'b110,
        op_add_c    = 3'b111
    } op_type;

    typedef struct packed {
        op_type     op;
        logic       dest_file;
        logic [2:0] bit_sel;
        logic [7:0] low_byte;
    } instr_type;
endpackage : exec_pkg

// >>> src/logic_and_bit_op_exec.sv
// Purpose: Executes AND, add-with-carry, bit set/clear and bit-test-skip.
// Assumes: Fetch stage holds i_instr_word for the whole decode quarter;
//          file read data is valid while o_file_addr is stable.
// Notes:   Four clocks per instruction cycle, one per quarter.
`timescale 1ns/100ps
`default_nettype none
module logic_and_bit_op_exec
    import exec_pkg::*;
#(
    parameter int DATA_W = 8
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_sys_rst,
    input  wire logic [15:0] i_instr_word,
    input  wire logic [7:0]  i_file_rdata,
    input  wire logic [3:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [7:0]  o_rdata,
    output logic      [1:0]  o_phase,
    output logic      [7:0]  o_file_addr,
    output logic      [7:0]  o_file_wdata,
    output logic             o_file_we,
    output logic             o_skip
);
    if (DATA_W != 8) begin : g_chk
        $error("DATA_W must be 8");
    end

    function automatic op_type decode_op(input logic [15:0] w);
        op_type r;
        r = op_nop;
        if (w[15:8] == OPC_AND_LIT)       r = op_and_lit;
        else if (w[15:9] == OPC_AND_FILE) r = op_and_file;
        else if (w[15:9] == OPC_ADD_C)    r = op_add_c;
        else if (w[15:11] == OPC_BIT_CLR) r = op_bit_clr;
        else if (w[15:11] == OPC_BIT_SET) r = op_bit_set;
        else if (w[15:11] == OPC_SKIP_CLR) r = op_skip_clr;
        else if (w[15:11] == OPC_SKIP_SET) r = op_skip_set;
        return r;
    endfunction : decode_op

    function automatic logic is_zero(input logic [7:0] v);
        return v == 8'h00;
    endfunction : is_zero

    phase_type  phase_r;
    phase_type  phase_nxt;
    instr_type  ins_r;
    instr_type  ins_nxt;
    logic       run_r;
    logic [7:0] work_r;
    logic [3:0] status_r;
    logic [7:0] opnd_r;
    logic [7:0] result_r;
    logic [3:0] flags_r;
    logic       skip_pend_r;
    logic       wr_work_r;
    logic       skip_nxt;
    logic [8:0] sum;
    logic [4:0] half;
    logic [7:0] result_nxt;
    logic [3:0] flags_nxt;
    logic       wr_work_nxt;
    logic       wr_file_nxt;
    logic       bit_val;

    // Quarter-cycle sequencer; holds in decode while stopped
    assign phase_nxt = (phase_r != ph_decode || run_r) ? phase_type'(phase_r + 2'h1) : phase_r;

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            phase_r <= ph_decode;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    always_comb begin
        ins_nxt           = '0;
        ins_nxt.op        = decode_op(i_instr_word);
        ins_nxt.dest_file = i_instr_word[8];
        ins_nxt.bit_sel   = i_instr_word[10:8];
        ins_nxt.low_byte  = i_instr_word[7:0];
        if (skip_pend_r) begin
            ins_nxt.op = op_nop;
        end
    end

    // Decode quarter: latch instruction and present file address
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ins_r       <= '0;
            o_file_addr <= 8'h00;
        end else if (phase_r == ph_decode && run_r) begin
            ins_r       <= ins_nxt;
            o_file_addr <= ins_nxt.low_byte;
        end
    end

    // Read quarter: literal or file operand
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            opnd_r <= 8'h00;
        end else if (phase_r == ph_read) begin
            opnd_r <= (ins_r.op == op_and_lit) ? ins_r.low_byte : i_file_rdata;
        end
    end

    assign bit_val = opnd_r[ins_r.bit_sel];
    assign sum     = {1'b0, work_r} + {1'b0, opnd_r} + {8'h00, status_r[ST_C_BIT]};
    assign half    = {1'b0, work_r[3:0]} + {1'b0, opnd_r[3:0]} + {4'h0, status_r[ST_C_BIT]};

    always_comb begin
        result_nxt  = opnd_r;
        flags_nxt   = status_r;
        wr_work_nxt = 1'b0;
        wr_file_nxt = 1'b0;
        skip_nxt    = 1'b0;
        case (ins_r.op)
            op_and_lit: begin
                result_nxt          = work_r & opnd_r;
                flags_nxt[ST_Z_BIT] = is_zero(result_nxt);
                wr_work_nxt         = 1'b1;
            end
            op_and_file: begin
                result_nxt          = work_r & opnd_r;
                flags_nxt[ST_Z_BIT] = is_zero(result_nxt);
                wr_work_nxt         = !ins_r.dest_file;
                wr_file_nxt         = ins_r.dest_file;
            end
            op_add_c: begin
                result_nxt           = sum[7:0];
                flags_nxt[ST_C_BIT]  = sum[8];
                flags_nxt[ST_DC_BIT] = half[4];
                flags_nxt[ST_OV_BIT] = (work_r[7] == opnd_r[7]) && (sum[7] != work_r[7]);
                flags_nxt[ST_Z_BIT]  = is_zero(sum[7:0]);
                wr_work_nxt          = !ins_r.dest_file;
                wr_file_nxt          = ins_r.dest_file;
            end
            op_bit_clr: begin
                result_nxt[ins_r.bit_sel] = 1'b0;
                wr_file_nxt               = 1'b1;
            end
            op_bit_set: begin
                result_nxt[ins_r.bit_sel] = 1'b1;
                wr_file_nxt               = 1'b1;
            end
            op_skip_clr: begin
                skip_nxt = !bit_val;
            end
            op_skip_set: begin
                skip_nxt = bit_val;
            end
            default: begin
                result_nxt = opnd_r;
            end
        endcase
    end

    // Process quarter: result, flags and file strobe for the write quarter
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            result_r     <= 8'h00;
            flags_r      <= STATUS_RST;
            wr_work_r    <= 1'b0;
            o_file_we    <= 1'b0;
            o_file_wdata <= 8'h00;
        end else if (phase_r == ph_process) begin
            result_r     <= result_nxt;
            flags_r      <= flags_nxt;
            wr_work_r    <= wr_work_nxt;
            o_file_we    <= wr_file_nxt;
            o_file_wdata <= result_nxt;
        end else begin
            o_file_we <= 1'b0;
        end
    end

    // Skip bookkeeping: discard one fetched word
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            skip_pend_r <= 1'b0;
        end else if (phase_r == ph_process && skip_nxt) begin
            skip_pend_r <= 1'b1;
        end else if (phase_r == ph_decode && run_r) begin
            skip_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_skip <= 1'b0;
        end else if (phase_r == ph_decode && run_r) begin
            o_skip <= skip_pend_r;
        end else if (phase_r == ph_write) begin
            o_skip <= 1'b0;
        end
    end

    // Working register and flags; write quarter beats a software write
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            work_r   <= WORK_RST;
            status_r <= STATUS_RST;
        end else if (phase_r == ph_write) begin
            if (wr_work_r) begin
                work_r <= result_r;
            end
            status_r <= flags_r;
        end else if (i_wr && i_addr == OFS_WORK) begin
            work_r <= i_wdata;
        end else if (i_wr && i_addr == OFS_STATUS) begin
            status_r <= i_wdata[3:0];
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            run_r <= CTRL_RST;
        end else if (i_wr && i_addr == OFS_CTRL) begin
            run_r <= i_wdata[CTRL_RUN_BIT];
        end
    end

    // Read port, data one cycle after the strobe
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                OFS_CTRL:   o_rdata <= {7'h00, run_r};
                OFS_WORK:   o_rdata <= work_r;
                OFS_STATUS: o_rdata <= {4'h0, status_r};
                OFS_STATE:  o_rdata <= {5'h00, skip_pend_r, phase_r};
                default:    o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_phase <= 2'h0;
        end else begin
            o_phase <= phase_nxt;
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    logic take;
    assign take = phase_r == ph_decode && run_r && !skip_pend_r;

    AST_AND_LIT: assert property (
        take && i_instr_word[15:8] == OPC_AND_LIT && !i_wr ##1 !i_wr [*3]
        |=> work_r == ($past(work_r, 4) & $past(i_instr_word[7:0], 4)))
        else $error("literal AND result wrong");
    AST_ZERO: assert property (
        phase_r == ph_write && ins_r.op == op_and_lit
        |=> status_r[ST_Z_BIT] == (work_r == 8'h00))
        else $error("zero flag wrong");
    AST_AND_FILE_DEST: assert property (
        take && decode_op(i_instr_word) == op_and_file && i_instr_word[8]
        |-> ##3 o_file_we && o_file_wdata == (work_r & opnd_r))
        else $error("file AND not written back");
    AST_AND_FILE_W: assert property (
        phase_r == ph_write && ins_r.op == op_and_file
        |=> o_file_we == 1'b0 && status_r[ST_Z_BIT] == ($past(result_r) == 8'h00)
            && status_r[ST_OV_BIT] == $past(status_r[ST_OV_BIT]) && status_r[1:0] == $past(status_r[1:0]))
        else $error("file AND touched other flags");
    AST_BIT_CLR: assert property (
        phase_r == ph_process && ins_r.op == op_bit_clr
        |=> o_file_we && !o_file_wdata[ins_r.bit_sel] ##1 status_r == $past(status_r, 2))
        else $error("bit clear wrong");
    AST_BIT_SET: assert property (
        phase_r == ph_process && ins_r.op == op_bit_set
        |=> o_file_we && o_file_wdata[ins_r.bit_sel] ##1 status_r == $past(status_r, 2))
        else $error("bit set wrong");
    AST_SKIP_CLR: assert property (
        phase_r == ph_read && ins_r.op == op_skip_clr && !i_file_rdata[ins_r.bit_sel]
        |-> ##2 skip_pend_r && !o_file_we)
        else $error("skip-if-clear missed");
    AST_SKIP_SET: assert property (
        phase_r == ph_read && ins_r.op == op_skip_set && !i_file_rdata[ins_r.bit_sel]
        |-> ##2 !skip_pend_r)
        else $error("skip-if-set skipped wrongly");
    AST_SKIP_NOP: assert property (
        phase_r == ph_decode && run_r && skip_pend_r
        |=> (o_skip && ins_r.op == op_nop) [*3] ##1 !o_skip)
        else $error("skip cycle not a no-operation");
    AST_ADD_C: assert property (
        phase_r == ph_process && ins_r.op == op_add_c
        |=> result_r == 8'(work_r + $past(opnd_r) + {7'h00, status_r[ST_C_BIT]}))
        else $error("add-with-carry sum wrong");
endmodule : logic_and_bit_op_exec
`default_nettype wire

// >>> bench/logic_and_bit_op_exec_tb.sv
// Purpose: Self-checking bench for the logic and bit-op executor.
// Assumes: Bench plays fetch stage, data memory and register master.
// Notes:   Each instruction reads back W and STATUS left by the one before; the first reads those set by register writes.
`timescale 1ns/100ps
`default_nettype none
module logic_and_bit_op_exec_tb;
    import exec_pkg::*;
    localparam logic [7:0] TOPS [8]  = '{8'hB5, 8'h0A, 8'h10, 8'h88, 8'h80, 8'h98, 8'h90, 8'h00};
    localparam logic [7:0] MASKS [8] = '{8'h00, 8'h01, 8'h01, 8'h07, 8'h07, 8'h07, 8'h07, 8'h00};
    logic        i_clk_sys    = 1'b0;
    logic        i_sys_rst    = 1'b1;
    logic [15:0] i_instr_word = 16'h0000;
    logic [7:0]  i_file_rdata;
    logic [3:0]  i_addr       = 4'h0;
    logic [7:0]  i_wdata      = 8'h00;
    logic        i_wr         = 1'b0;
    logic        i_rd         = 1'b0;
    logic [7:0]  o_rdata;
    logic [1:0]  o_phase;
    logic [7:0]  o_file_addr;
    logic [7:0]  o_file_wdata;
    logic        o_file_we;
    logic        o_skip;
    logic [7:0]  mem [256];
    logic [7:0]  w_m          = 8'hA3;
    logic [3:0]  st_m         = 4'h1;
    logic        skip_m       = 1'b0;
    int          miscompares  = 0;
    int          checks_done  = 0;
    int          cycles       = 0;
    int          seed         = 32'h4ef3_f7f8;

    logic_and_bit_op_exec #(.DATA_W(8)) dut (
        .i_clk_sys    (i_clk_sys),
        .i_sys_rst    (i_sys_rst),
        .i_instr_word (i_instr_word),
        .i_file_rdata (i_file_rdata),
        .i_addr       (i_addr),
        .i_wdata      (i_wdata),
        .i_wr         (i_wr),
        .i_rd         (i_rd),
        .o_rdata      (o_rdata),
        .o_phase      (o_phase),
        .o_file_addr  (o_file_addr),
        .o_file_wdata (o_file_wdata),
        .o_file_we    (o_file_we),
        .o_skip       (o_skip)
    );

    // Data memory answers in the same cycle
    assign i_file_rdata = mem[o_file_addr];

    always #5 i_clk_sys = ~i_clk_sys;

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    always @(posedge i_clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            end_of_test();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr    <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge i_clk_sys);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd   <= 1'b0;
        #1 chk(o_rdata, exp);
    endtask : reg_rd

    // Presents one word for the next decode quarter and checks its results
    task automatic exec(input logic [15:0] word);
        logic [7:0] f;
        logic [7:0] r;
        logic [7:0] ed;
        logic [8:0] sum;
        logic       ewe;
        logic       wz;
        logic       dst;
        logic       dis;
        int         n;
        n = 0;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (o_phase !== 2'd3 && n < 8);
        i_instr_word <= word;
        @(posedge i_clk_sys);
        i_instr_word <= 16'h0000;
        i_rd         <= 1'b1;
        i_addr       <= OFS_WORK;
        @(posedge i_clk_sys);
        i_addr       <= OFS_STATUS;
        #1 chk(o_rdata, w_m);
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 chk({4'h0, o_rdata[3:0]}, {4'h0, st_m});
        f   = mem[word[7:0]];
        ewe = 1'b0;
        wz  = 1'b0;
        dst = 1'b0;
        ed  = 8'h00;
        r   = 8'h00;
        dis = skip_m;
        skip_m = 1'b0;
        if (!dis) begin
            if (word[15:8] == OPC_AND_LIT) begin
                r   = w_m & word[7:0];
                w_m = r;
                wz  = 1'b1;
            end else if (word[15:9] == OPC_AND_FILE) begin
                r   = w_m & f;
                wz  = 1'b1;
                dst = 1'b1;
            end else if (word[15:9] == OPC_ADD_C) begin
                sum = w_m + f + st_m[ST_C_BIT];
                r   = sum[7:0];
                st_m[ST_DC_BIT] = (w_m[3:0] + f[3:0] + st_m[ST_C_BIT]) > 15;
                st_m[ST_OV_BIT] = (w_m[7] == f[7]) && (r[7] != w_m[7]);
                st_m[ST_C_BIT]  = sum[8];
                wz  = 1'b1;
                dst = 1'b1;
            end else if (word[15:11] == OPC_BIT_CLR || word[15:11] == OPC_BIT_SET) begin
                ewe = 1'b1;
                ed  = f;
                ed[word[10:8]] = (word[15:11] == OPC_BIT_SET);
            end else if (word[15:11] == OPC_SKIP_CLR) begin
                skip_m = (f[word[10:8]] == 1'b0);
            end else if (word[15:11] == OPC_SKIP_SET) begin
                skip_m = (f[word[10:8]] == 1'b1);
            end
        end
        if (dst && word[8]) begin
            ewe = 1'b1;
            ed  = r;
        end else if (dst) begin
            w_m = r;
        end
        if (wz) begin
            st_m[ST_Z_BIT] = (r == 8'h00);
        end
        #1;
        chk({6'h00, o_phase}, 8'h03);
        chk({7'h00, o_skip}, {7'h00, dis});
        chk({7'h00, o_file_we}, {7'h00, ewe});
        if (ewe) begin
            chk(o_file_addr, word[7:0]);
            chk(o_file_wdata, ed);
            mem[word[7:0]] = ed;
        end
    endtask : exec

    initial begin
        logic [15:0] rnd;
        logic [2:0]  sel;
        for (int k = 0; k < 256; k++) begin
            mem[k] = 8'($random(seed));
        end
        mem[8'h10] = 8'h02;
        repeat (12) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        reg_rd(OFS_WORK, WORK_RST);
        reg_wr(OFS_STATE, 8'hFF);
        reg_rd(OFS_STATE, 8'h00);
        chk({6'h00, o_phase}, 8'h00);
        reg_wr(4'hF, 8'h5A);
        reg_rd(4'hF, 8'h00);
        reg_wr(OFS_WORK, w_m);
        reg_wr(OFS_STATUS, {4'h0, st_m});
        reg_wr(OFS_CTRL, 8'h01);
        reg_rd(OFS_CTRL, 8'h01);
        exec(16'hB55F);
        exec(16'h9910);
        exec(16'h9110);
        exec(16'h9110);
        exec(16'h9110);
        exec(16'h0B10);
        exec(16'h8910);
        exec(16'h9910);
        exec(16'h8110);
        exec(16'h8110);
        exec(16'h0B10);
        exec(16'h0A10);
        for (int k = 0; k < 400; k++) begin
            rnd = 16'($random(seed));
            sel = 3'($random(seed));
            exec({TOPS[sel] | (rnd[15:8] & MASKS[sel]), (sel == 3'd0) ? rnd[7:0] : {4'h0, rnd[3:0]}});
        end
        exec(16'h0000);
        end_of_test();
    end
endmodule : logic_and_bit_op_exec_tb
`default_nettype wire
